// *** verilog/ahac_pkg.sv ***
// constants and types of the air handler alarm and accessory control
package ahac_pkg;

    // =========================================================
    // timing
    localparam longint CLK_HZ = 50_000_000;
    localparam longint CLOSE_TIME_S = 30;
    localparam longint CLOSE_CYCLES = CLOSE_TIME_S * CLK_HZ;

    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_HIST_IDX = 8'h08;
    localparam logic [7:0] OFS_HIST_DATA = 8'h0c;

    // =========================================================
    // control register fields and reset value
    localparam int CTRL_HUM_LSB = 0;
    localparam int CTRL_WITH_BLOWER = 2;
    localparam int CTRL_FAN_LSB = 3;
    localparam int CTRL_EMERG_EN = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // =========================================================
    // status register fields
    localparam int STAT_ALARM = 0;
    localparam int STAT_EMERG = 1;
    localparam int STAT_CFG_ERR = 2;
    localparam int STAT_KIT_LSB = 3;
    localparam int STAT_RELAY = 6;
    localparam int STAT_BLOWER = 7;
    localparam int STAT_CODE_LSB = 8;

    // =========================================================
    // fault codes shown on the display
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_AUX_ALARM = 8'h0a;
    localparam logic [7:0] FAULT_HEATER_CFG = 8'hed;

    // =========================================================
    // humidifier set-up modes
    typedef enum logic [1:0] {
        HUM_OFF = 2'h0,
        HUM_HEAT_ONLY = 2'h1,
        HUM_INDEPENDENT = 2'h2
    } ahac_hum_mode_t;

    // alarm supervision states
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_ALARM = 3'b010,
        ST_QUALIFY = 3'b100
    } ahac_alarm_state_t;

endpackage

// *** verilog/ahac_fault_hist.sv ***
// small fault history memory, registered read port, never erased by clears
`timescale 1ns/100ps
module ahac_fault_hist #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_code,
    // read side
    input wire logic [AW-1:0] rd_idx,
    output logic [7:0] rd_code,
    output logic [AW:0] count
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW:0] count;
        logic [7:0] rd_code;
    } ahac_hist_state_t;

    ahac_hist_state_t st_ff;
    ahac_hist_state_t nxt_st;

    generate
        if (DEPTH != (1 << AW)) begin : g_bad_depth
            $error("history depth must equal two to the power of AW");
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        // newest entry sits at the write pointer minus one; oldest overwritten
        if (wr_en) begin
            nxt_st.mem[st_ff.wr_ptr] = wr_code;
            nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
            if (st_ff.count != DEPTH[AW:0]) begin
                nxt_st.count = st_ff.count + 1'b1;
            end
        end
        // index 0 reads the most recent fault
        nxt_st.rd_code = st_ff.mem[st_ff.wr_ptr - 1'b1 - rd_idx];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_code = st_ff.rd_code;
    assign count = st_ff.count;

endmodule

// *** verilog/ahac_ctrl.sv ***
// air handler alarm supervision, heater kit selection and accessory relay
// What this block does
// - an open contact stops blower and outdoor unit and shows alarm code.
// - operation and display recover after 30 s of steady closed contact.
// - a cleared alarm stays recorded in the fault history.
// - on lost thermostat link, emergency mode takes the kit from switches.
// - switch patterns 1111 down to 1001 select the first to seventh kit.
// - all four switches off is the factory default and means no heater kit.
// - a bad pattern at communicating start-up latches the error until reset.
// - relay is open by default and follows humidification or the blower.
// - heat-only mode closes relay only while heat and humidify both call.
// - in humidifier off mode the relay never closes.
// - independent mode: relay follows humidify call, open while cooling.
// - independent mode: idle humidify call runs blower at set speed.
// - in with-blower mode relay is closed exactly while the blower runs.
`timescale 1ns/100ps
module ahac_ctrl #(
    parameter longint CLOSE_CYCLES = ahac_pkg::CLOSE_CYCLES,
    parameter int HIST_DEPTH = 8,
    parameter int HIST_AW = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // alarm contact, high while the loop has continuity
    input wire logic alarm_terminal_a,
    // configuration switches, high is on
    input wire logic heater_sel_sw_first,
    input wire logic heater_sel_sw_second,
    input wire logic heater_sel_sw_third,
    input wire logic heater_sel_sw_fourth,
    // thermostat side
    input wire logic comm_mode,
    input wire logic comm_lost,
    input wire logic heat_call,
    input wire logic cool_call,
    input wire logic fan_call,
    input wire logic humidify_call,
    input wire logic outdoor_call,
    input wire logic [1:0] tstat_fan_speed,
    input wire logic [2:0] tstat_heater_kit,
    // equipment outputs
    output logic blower_run,
    output logic [1:0] blower_speed,
    output logic outdoor_unit_run,
    output logic [2:0] heater_kit,
    output logic [7:0] fault_code,
    output logic accessory_contact_out
);

    // =========================================================
    // state
    localparam int CW = 31;
    localparam logic [CW-1:0] CLOSE_LAST = CW'(CLOSE_CYCLES - 1);

    typedef struct packed {
        ahac_pkg::ahac_alarm_state_t alarm_st;
        logic [CW-1:0] close_cnt;
        logic [5:0] ctrl;
        logic [HIST_AW-1:0] hist_idx;
        logic started;
        logic cfg_err;
        logic blower_run;
        logic [1:0] blower_speed;
        logic outdoor_run;
        logic [2:0] heater_kit;
        logic [7:0] fault_code;
        logic relay;
        logic [31:0] prdata;
        logic hist_wr;
        logic [7:0] hist_code;
    } ahac_state_t;

    ahac_state_t st_ff;
    ahac_state_t nxt_st;

    logic [7:0] hist_rd_code;
    logic [HIST_AW:0] hist_count;

    generate
        if (CLOSE_CYCLES < 1 || CLOSE_CYCLES >= (64'h1 << CW)) begin : g_bad
            $error("close qualification count out of range");
        end
    endgenerate

    // =========================================================
    // switch decode, {valid, kit}; kit 0 means none installed
    function automatic logic [3:0] ahac_decode_kit(input logic [3:0] sw);
        case (sw)
            4'b0000: ahac_decode_kit = 4'b1_000;
            4'b1111: ahac_decode_kit = 4'b1_001;
            4'b1110: ahac_decode_kit = 4'b1_010;
            4'b1101: ahac_decode_kit = 4'b1_011;
            4'b1100: ahac_decode_kit = 4'b1_100;
            4'b1011: ahac_decode_kit = 4'b1_101;
            4'b1010: ahac_decode_kit = 4'b1_110;
            4'b1001: ahac_decode_kit = 4'b1_111;
            default: ahac_decode_kit = 4'b0_000;
        endcase
    endfunction

    // =========================================================
    // next state
    always_comb begin
        logic [3:0] sw;
        logic [3:0] dec;
        logic alarm_on;
        logic emerg;
        logic ind_idle_hum;
        logic run;
        logic hum_rel;
        logic setup_ph;
        logic acc_ph;
        sw = '0;
        dec = '0;
        alarm_on = 1'b0;
        emerg = 1'b0;
        ind_idle_hum = 1'b0;
        run = 1'b0;
        hum_rel = 1'b0;
        setup_ph = 1'b0;
        acc_ph = 1'b0;
        nxt_st = st_ff;
        nxt_st.hist_wr = 1'b0;
        sw = {heater_sel_sw_first, heater_sel_sw_second,
              heater_sel_sw_third, heater_sel_sw_fourth};
        dec = ahac_decode_kit(sw);

        // alarm supervision; open contact is the alarm condition
        case (st_ff.alarm_st)
            ahac_pkg::ST_NORMAL: begin
                if (!alarm_terminal_a) begin
                    nxt_st.alarm_st = ahac_pkg::ST_ALARM;
                    nxt_st.hist_wr = 1'b1;
                    nxt_st.hist_code = ahac_pkg::FAULT_AUX_ALARM;
                end
            end
            ahac_pkg::ST_ALARM: begin
                nxt_st.close_cnt = '0;
                if (alarm_terminal_a) begin
                    nxt_st.alarm_st = ahac_pkg::ST_QUALIFY;
                end
            end
            ahac_pkg::ST_QUALIFY: begin
                if (!alarm_terminal_a) begin
                    // reopen restarts the full interval
                    nxt_st.alarm_st = ahac_pkg::ST_ALARM;
                    nxt_st.close_cnt = '0;
                end else if (st_ff.close_cnt == CLOSE_LAST) begin
                    nxt_st.alarm_st = ahac_pkg::ST_NORMAL;
                    nxt_st.close_cnt = '0;
                end else begin
                    nxt_st.close_cnt = st_ff.close_cnt + 1'b1;
                end
            end
            default: begin
                nxt_st.alarm_st = ahac_pkg::ST_ALARM;
                nxt_st.close_cnt = '0;
            end
        endcase
        // the closed wait still counts as alarm, so equipment stays off
        alarm_on = (st_ff.alarm_st != ahac_pkg::ST_NORMAL);

        // start-up check, caught once after reset release; only reset clears
        nxt_st.started = 1'b1;
        if (!st_ff.started && comm_mode && !dec[3]) begin
            nxt_st.cfg_err = 1'b1;
            // one history write per cycle; an alarm entry must not be lost
            if (!nxt_st.hist_wr) begin
                nxt_st.hist_wr = 1'b1;
                nxt_st.hist_code = ahac_pkg::FAULT_HEATER_CFG;
            end
        end

        // heater kit source
        emerg = comm_lost && st_ff.ctrl[ahac_pkg::CTRL_EMERG_EN];
        nxt_st.heater_kit = emerg ? dec[2:0] : tstat_heater_kit;

        // blower
        ind_idle_hum = (st_ff.ctrl[1:0] == ahac_pkg::HUM_INDEPENDENT)
            && humidify_call && !heat_call && !cool_call && !fan_call;
        run = heat_call || cool_call || fan_call || ind_idle_hum;
        nxt_st.blower_run = run && !alarm_on;
        if (ind_idle_hum) begin
            nxt_st.blower_speed =
                st_ff.ctrl[ahac_pkg::CTRL_FAN_LSB +: 2];
        end else begin
            nxt_st.blower_speed = tstat_fan_speed;
        end
        nxt_st.outdoor_run = outdoor_call && !alarm_on;

        // display; alarm outranks the configuration error
        if (alarm_on) begin
            nxt_st.fault_code = ahac_pkg::FAULT_AUX_ALARM;
        end else if (nxt_st.cfg_err) begin
            nxt_st.fault_code = ahac_pkg::FAULT_HEATER_CFG;
        end else begin
            nxt_st.fault_code = ahac_pkg::FAULT_NONE;
        end

        // accessory relay, a dry contact only
        case (st_ff.ctrl[1:0])
            ahac_pkg::HUM_HEAT_ONLY:
                hum_rel = heat_call && humidify_call;
            ahac_pkg::HUM_INDEPENDENT:
                hum_rel = humidify_call && !cool_call;
            default:
                hum_rel = 1'b0;
        endcase
        if (st_ff.ctrl[ahac_pkg::CTRL_WITH_BLOWER]) begin
            // follows the blower output as it changes, same edge
            nxt_st.relay = nxt_st.blower_run;
        end else begin
            nxt_st.relay = hum_rel;
        end

        // apb: data loaded in setup, taken in the access cycle
        setup_ph = psel && !penable;
        acc_ph = psel && penable;
        if (setup_ph) begin
            nxt_st.prdata = '0;
            case (paddr)
                ahac_pkg::OFS_CTRL:
                    nxt_st.prdata[5:0] = st_ff.ctrl;
                ahac_pkg::OFS_STATUS: begin
                    nxt_st.prdata[ahac_pkg::STAT_ALARM] = alarm_on;
                    nxt_st.prdata[ahac_pkg::STAT_EMERG] = emerg;
                    nxt_st.prdata[ahac_pkg::STAT_CFG_ERR] = st_ff.cfg_err;
                    nxt_st.prdata[ahac_pkg::STAT_KIT_LSB +: 3] =
                        st_ff.heater_kit;
                    nxt_st.prdata[ahac_pkg::STAT_RELAY] = st_ff.relay;
                    nxt_st.prdata[ahac_pkg::STAT_BLOWER] = st_ff.blower_run;
                    nxt_st.prdata[ahac_pkg::STAT_CODE_LSB +: 8] =
                        st_ff.fault_code;
                end
                ahac_pkg::OFS_HIST_IDX:
                    nxt_st.prdata[HIST_AW-1:0] = st_ff.hist_idx;
                ahac_pkg::OFS_HIST_DATA: begin
                    nxt_st.prdata[7:0] = hist_rd_code;
                    nxt_st.prdata[8 +: HIST_AW + 1] = hist_count;
                end
                default: nxt_st.prdata = '0;
            endcase
        end
        if (acc_ph && pwrite) begin
            case (paddr)
                ahac_pkg::OFS_CTRL:
                    nxt_st.ctrl = pwdata[5:0];
                ahac_pkg::OFS_HIST_IDX:
                    nxt_st.hist_idx = pwdata[HIST_AW-1:0];
                default: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.alarm_st <= ahac_pkg::ST_NORMAL;
            st_ff.ctrl <= ahac_pkg::CTRL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // fault history
    ahac_fault_hist #(
        .DEPTH(HIST_DEPTH),
        .AW(HIST_AW)
    ) u_hist (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(st_ff.hist_wr),
        .wr_code(st_ff.hist_code),
        .rd_idx(st_ff.hist_idx),
        .rd_code(hist_rd_code),
        .count(hist_count)
    );

    // =========================================================
    // outputs
    // zero-wait slave; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable &&
        (paddr != ahac_pkg::OFS_CTRL) && (paddr != ahac_pkg::OFS_STATUS) &&
        (paddr != ahac_pkg::OFS_HIST_IDX) &&
        (paddr != ahac_pkg::OFS_HIST_DATA);
    assign prdata = st_ff.prdata;
    assign blower_run = st_ff.blower_run;
    assign blower_speed = st_ff.blower_speed;
    assign outdoor_unit_run = st_ff.outdoor_run;
    assign heater_kit = st_ff.heater_kit;
    assign fault_code = st_ff.fault_code;
    assign accessory_contact_out = st_ff.relay;

endmodule

// *** verif/ahac_ctrl_monitor.sv ***
// port checker for alarm, heater kit and relay behaviour
`timescale 1ns/100ps
module ahac_ctrl_monitor #(
    parameter longint CLOSE_CYCLES = 20
) (
    // clock, reset and apb
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    // contact, switches and calls
    input logic alarm_terminal_a,
    input logic heater_sel_sw_first,
    input logic heater_sel_sw_second,
    input logic heater_sel_sw_third,
    input logic heater_sel_sw_fourth,
    input logic comm_lost,
    input logic heat_call,
    input logic cool_call,
    input logic fan_call,
    input logic humidify_call,
    // equipment outputs
    input logic blower_run,
    input logic [1:0] blower_speed,
    input logic outdoor_unit_run,
    input logic [2:0] heater_kit,
    input logic [7:0] fault_code,
    input logic accessory_contact_out
);
    // ====================================================
    // shadow control word and closed-contact run length
    logic [5:0] ctl_ff;
    longint run_ff;
    logic [3:0] sw;
    logic aux, quiet, independent_humidify_mode, heat_only, off_m;
    assign sw = {heater_sel_sw_first, heater_sel_sw_second,
        heater_sel_sw_third, heater_sel_sw_fourth};
    assign aux = fault_code == ahac_pkg::FAULT_AUX_ALARM;
    // saturating, so a long closed spell cannot wrap
    assign quiet = run_ff == CLOSE_CYCLES + 3;
    assign off_m = !ctl_ff[2] && ctl_ff[1:0] != 2'h1 && ctl_ff[1:0] != 2'h2;
    assign heat_only = !ctl_ff[2] && ctl_ff[1:0] == 2'h1;
    assign independent_humidify_mode = !ctl_ff[2] && ctl_ff[1:0] == 2'h2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= ahac_pkg::CTRL_RESET;
            run_ff <= 0;
        end else begin
            if (psel && penable && pwrite && paddr == ahac_pkg::OFS_CTRL) begin
                ctl_ff <= pwdata[5:0];
            end
            if (!alarm_terminal_a) begin
                run_ff <= 0;
            end else if (!quiet) begin
                run_ff <= run_ff + 1;
            end
        end
    end
    function automatic logic [2:0] kit_of(input logic [3:0] s);
        return s == 4'h0 ? 3'h0 : 3'(5'h10 - 5'(s));
    endfunction
    // ====================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_open;
        !alarm_terminal_a;
    endsequence
    sequence s_stopped;
        !blower_run && !outdoor_unit_run && aux;
    endsequence
    chk_alarm_stop: assert property (s_open |=> ##1 s_stopped)
        else $error("alarm left equipment running");
    chk_resume_early: assert property (
        $fell(aux) && $past(presetn) |-> run_ff > CLOSE_CYCLES)
        else $error("alarm cleared before the closed interval");
    chk_resume_late: assert property (
        run_ff == CLOSE_CYCLES + 2 |-> !aux)
        else $error("alarm held after the closed interval");
    chk_relay_off: assert property (
        $past(off_m) |-> !accessory_contact_out)
        else $error("relay closed in humidifier off mode");
    chk_relay_blower: assert property (
        $past(ctl_ff[2]) |-> accessory_contact_out == blower_run)
        else $error("relay not following blower");
    chk_relay_heat: assert property (
        $past(heat_only && quiet)
        |-> accessory_contact_out == $past(heat_call && humidify_call))
        else $error("relay wrong in heat-only mode");
    chk_relay_indep: assert property (
        $past(independent_humidify_mode && quiet)
        |-> accessory_contact_out == $past(humidify_call && !cool_call))
        else $error("relay wrong in independent mode");
    chk_idle_fan: assert property (
        $past(independent_humidify_mode && quiet && humidify_call && !heat_call && !cool_call
        && !fan_call) |-> blower_run && blower_speed == $past(ctl_ff[4:3]))
        else $error("idle humidify blower wrong");
    chk_kit_emerg: assert property (
        $past(ctl_ff[5] && comm_lost && (sw == 4'h0 || sw > 4'h8))
        |-> heater_kit == kit_of($past(sw)))
        else $error("emergency heater kit wrong");
    chk_cfg_sticky: assert property (
        fault_code == ahac_pkg::FAULT_HEATER_CFG
        |=> fault_code != ahac_pkg::FAULT_NONE)
        else $error("configuration error cleared without reset");
endmodule

bind ahac_ctrl ahac_ctrl_monitor #(.CLOSE_CYCLES(CLOSE_CYCLES)) mon_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .alarm_terminal_a(alarm_terminal_a),
    .heater_sel_sw_first(heater_sel_sw_first),
    .heater_sel_sw_second(heater_sel_sw_second),
    .heater_sel_sw_third(heater_sel_sw_third),
    .heater_sel_sw_fourth(heater_sel_sw_fourth),
    .comm_lost(comm_lost), .heat_call(heat_call), .cool_call(cool_call),
    .fan_call(fan_call), .humidify_call(humidify_call),
    .blower_run(blower_run), .blower_speed(blower_speed),
    .outdoor_unit_run(outdoor_unit_run), .heater_kit(heater_kit),
    .fault_code(fault_code), .accessory_contact_out(accessory_contact_out));

// *** verif/ahac_tstat_model.sv ***
// thermostat calls and auxiliary alarm contact, one edge behind the bench
`timescale 1ns/100ps
module ahac_tstat_model (
    // clock and bench command: open, heat, cool, fan, humidify, outdoor
    input logic pclk,
    input logic [5:0] want,
    // calls and contact towards the control
    output logic alarm_terminal_a = 1'b1,
    output logic heat_call = 1'b0,
    output logic cool_call = 1'b0,
    output logic fan_call = 1'b0,
    output logic humidify_call = 1'b0,
    output logic outdoor_call = 1'b0
);
    always @(posedge pclk) begin
        // closed in normal conditions, open only while alarmed
        alarm_terminal_a <= !want[5];
        {heat_call, cool_call, fan_call, humidify_call, outdoor_call}
            <= want[4:0];
    end
endmodule

// *** verif/ahac_ctrl_tb.sv ***
// self-checking bench for the alarm, heater kit and relay control
`timescale 1ns/100ps
module ahac_ctrl_tb;
    localparam longint CC = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rd_err;
    logic [3:0] sw = 4'h5;
    logic comm_mode = 1'b1;
    logic comm_lost = 1'b0;
    logic [2:0] tkit = 3'h5;
    logic [5:0] want = 6'h00;
    logic alarm_a, heat, cool, fan, hum, outd;
    logic blower_run, outdoor_unit_run, acc;
    logic [1:0] blower_speed;
    logic [2:0] heater_kit;
    logic [7:0] fault_code;
    int n_errors = 0;
    int cmp_count = 0;
    // ctrl, calls heat/cool/fan/humidify, expected relay
    logic [15:0] rt [10] = '{16'h0090, 16'h0390, 16'h0191, 16'h0110,
        16'h0180, 16'h0211, 16'h0291, 16'h0250, 16'h0421, 16'h0400};
    always #10 pclk = ~pclk;
    ahac_ctrl #(.CLOSE_CYCLES(CC)) ahac_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_terminal_a(alarm_a),
        .heater_sel_sw_first(sw[3]), .heater_sel_sw_second(sw[2]),
        .heater_sel_sw_third(sw[1]), .heater_sel_sw_fourth(sw[0]),
        .comm_mode(comm_mode), .comm_lost(comm_lost), .heat_call(heat),
        .cool_call(cool), .fan_call(fan), .humidify_call(hum),
        .outdoor_call(outd), .tstat_fan_speed(2'h1),
        .tstat_heater_kit(tkit), .blower_run(blower_run),
        .blower_speed(blower_speed), .outdoor_unit_run(outdoor_unit_run),
        .heater_kit(heater_kit), .fault_code(fault_code),
        .accessory_contact_out(acc));
    ahac_tstat_model ahac_tstat_model_i (
        .pclk(pclk), .want(want), .alarm_terminal_a(alarm_a),
        .heat_call(heat), .cool_call(cool), .fan_call(fan),
        .humidify_call(hum), .outdoor_call(outd));
    // ====================================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic cmp(input string what, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ====================================================
    // tests
    initial begin
        do_reset();
        cyc(3);
        cmp("cfg code", ahac_pkg::FAULT_HEATER_CFG, fault_code);
        apb(1'b0, ahac_pkg::OFS_CTRL, 32'h0000_0000);
        cmp("ctrl reset", ahac_pkg::CTRL_RESET, rd);
        cmp("relay reset", 32'h0000_0000, acc);
        apb(1'b0, 8'h10, 32'h0000_0000);
        cmp("unmapped data", 32'h0000_0000, rd);
        cmp("unmapped err", 32'h0000_0001, rd_err);
        sw <= 4'h0;
        cyc(3);
        cmp("cfg sticky", ahac_pkg::FAULT_HEATER_CFG, fault_code);
        do_reset();
        cyc(3);
        cmp("cfg cleared", ahac_pkg::FAULT_NONE, fault_code);
        @(posedge pclk);
        comm_mode <= 1'b0;
        sw <= 4'h5;
        do_reset();
        cyc(3);
        cmp("cfg not in comm", ahac_pkg::FAULT_NONE, fault_code);
        apb(1'b1, ahac_pkg::OFS_CTRL, 32'h0000_0020);
        comm_lost <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(posedge pclk);
            sw <= k == 0 ? 4'h0 : 4'(16 - k);
            cyc(2);
            cmp("emergency kit", k, heater_kit);
        end
        @(posedge pclk);
        comm_lost <= 1'b0;
        cyc(2);
        cmp("tstat kit", tkit, heater_kit);
        cyc(CC);
        foreach (rt[i]) begin
            apb(1'b1, ahac_pkg::OFS_CTRL, {24'h00_0000, rt[i][15:8]});
            want <= {1'b0, rt[i][7:4], 1'b0};
            cyc(4);
            cmp("relay", rt[i][0], acc);
        end
        apb(1'b1, ahac_pkg::OFS_CTRL, 32'h0000_0012);
        want <= 6'h02;
        cyc(4);
        cmp("idle fan", 32'h0000_0006, {blower_run, blower_speed});
        @(posedge pclk);
        want <= 6'h05;
        cyc(4);
        cmp("outdoor on", 32'h0000_0001, outdoor_unit_run);
        @(posedge pclk);
        want <= 6'h25;
        cyc(4);
        cmp("alarm out", {2'b00, ahac_pkg::FAULT_AUX_ALARM},
            {blower_run, outdoor_unit_run, fault_code});
        apb(1'b0, ahac_pkg::OFS_STATUS, 32'h0000_0000);
        cmp("status alarm", 32'h0000_0a29, rd);
        want <= 6'h05;
        cyc(CC - 2);
        @(posedge pclk);
        want <= 6'h25;
        cyc(2);
        @(posedge pclk);
        want <= 6'h05;
        cyc(CC - 1);
        cmp("alarm held", {2'b00, ahac_pkg::FAULT_AUX_ALARM},
            {blower_run, outdoor_unit_run, fault_code});
        cyc(6);
        cmp("resumed", {2'b11, ahac_pkg::FAULT_NONE},
            {blower_run, outdoor_unit_run, fault_code});
        apb(1'b1, ahac_pkg::OFS_HIST_IDX, 32'h0000_0000);
        apb(1'b0, ahac_pkg::OFS_HIST_DATA, 32'h0000_0000);
        cmp("history", {4'h1, ahac_pkg::FAULT_AUX_ALARM}, rd[11:0]);
        wrap_up();
    end
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule
